/* File: adtc_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Included by the top design module and the testbench
`ifndef ADTC_PARAMS_SVH
`define ADTC_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ADTC_OFF_CTRL 5'h00
`define ADTC_OFF_TRIG 5'h04
`define ADTC_OFF_MSTP 5'h08
`define ADTC_OFF_STAT 5'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADTC_CTRL_CODE_LSB 0
`define ADTC_CTRL_CODE_MSB 2
`define ADTC_CTRL_SCAN 3
`define ADTC_CTRL_START 4
`define ADTC_TRIG_SEL_LSB 6
`define ADTC_TRIG_SEL_MSB 7
`define ADTC_MSTP_ADC 9
`define ADTC_STAT_IRQ 0
`define ADTC_STAT_DMA 1

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define ADTC_CTRL_RESET 8'h00
`define ADTC_TRIG_RESET 8'h3f
`define ADTC_MSTP_RESET 16'h3fff
`define ADTC_TRIG_RSV_BASIC 8'h3f
`define ADTC_TRIG_RSV_EXT 8'h33

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ADTC_BUS_WAIT_CYCLES 1

`endif

/* File: adtc_pkg.sv */
// Purpose: Types shared by the converter control modules
// Assumes: adtc_params.svh holds the numbers
// Notes: None
package adtc_pkg;

  // ----------------------------------------
  // Trigger source encoding
  // ----------------------------------------
  typedef enum logic [1:0] {
    ADTC_TRG_OFF = 2'b00,
    ADTC_TRG_GTU = 2'b01,
    ADTC_TRG_TMR8 = 2'b10,
    ADTC_TRG_PIN = 2'b11
  } adtc_trig_src_t;

endpackage : adtc_pkg

/* File: adtc_chan_if.sv */
// Purpose: Channel code in, input mask out
// Assumes: Same clock on both sides
// Notes: Combinational carrier
`timescale 1ns/100ps
interface adtc_chan_if;
  logic [2:0] code;
  logic scan;
  logic [7:0] mask;
  modport ctrl (output code, output scan, input mask);
  modport dec (input code, input scan, output mask);
endinterface : adtc_chan_if

/* File: adtc_chan_decode.sv */
// Purpose: Analog input mask from channel code and scan bit
// Assumes: Code is stable while a conversion runs
// Notes: Purely combinational
`timescale 1ns/100ps
module adtc_chan_decode
  import adtc_pkg::*;
(
  adtc_chan_if.dec ch
);

  logic [3:0] group_mask;

  always_comb
  begin
    group_mask = 4'h0;
    if (ch.scan)
    begin
      unique case (ch.code[1:0])
        2'b00: group_mask = 4'h1;
        2'b01: group_mask = 4'h3;
        2'b10: group_mask = 4'h7;
        2'b11: group_mask = 4'hf;
      endcase
    end
    else
    begin
      group_mask = 4'(4'h1 << ch.code[1:0]);
    end
  end

  assign ch.mask = ch.code[2] ? {group_mask, 4'h0} : {4'h0, group_mask};

endmodule : adtc_chan_decode

/* File: adtc_top.sv */
// Purpose: Converter control: channel select, trigger select, module stop
// Assumes: Avalon-MM master on clk; trigger pin asynchronous
// Notes: Sequencer lives outside; it reports conv_done
//
// Overview of operation
// - A pending interrupt or transfer request stays set through module stop.
// - Single mode selects input n; scan mode scans first k+1 of group.
// - Trigger register returns to 0x3f on reset, standby and module stop.
// - Trigger field 7:6 selects off, timer unit, 8-bit timer or pin.
// - Reserved trigger register bits read one and ignore writes.
// - Setting stop bit 9 halts converter after the current bus cycle.
// - In module stop converter registers can be neither read nor written.
// - Module stop register resets to 0x3fff; kept through software standby.
// - Clearing stop bit releases module stop; bit resets to one.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "adtc_params.svh"
module adtc_top
  import adtc_pkg::*;
#(
  parameter bit EXT_VARIANT = 1'b0
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sw_standby,
  input wire logic gtu_trigger,
  input wire logic tmr8_trigger,
  input wire logic external_trigger_pin_n,
  input wire logic conv_done,
  input wire logic irq_enable,
  input wire logic dma_ack,
  output logic conv_start,
  output logic [7:0] chan_sel,
  output logic adc_stopped,
  output logic irq_out,
  output logic dma_req
);

  localparam logic [7:0] TRIG_RSV = EXT_VARIANT ? `ADTC_TRIG_RSV_EXT : `ADTC_TRIG_RSV_BASIC;

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_sync;
  logic [1:0] pin_sync_reg;
  logic pin_prev_reg;
  logic [1:0] sby_sync_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      pin_sync_reg <= 2'b11;
      pin_prev_reg <= 1'b1;
      sby_sync_reg <= 2'b00;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[0], external_trigger_pin_n};
      pin_prev_reg <= pin_sync_reg[1];
      sby_sync_reg <= {sby_sync_reg[0], sw_standby};
    end
  end

  // ----------------------------------------
  // Bus slave handshake
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] trig_reg;
  logic [15:0] mstp_reg;
  logic irq_pend_reg;
  logic dma_pend_reg;
  logic [31:0] rd_value;
  logic req;
  logic acc;
  logic wr_acc;
  logic stopped;
  logic conv_reg_sel;

  assign req = read | write;
  assign acc = req & ~waitrequest;
  assign stopped = mstp_reg[`ADTC_MSTP_ADC];
  assign conv_reg_sel = (address != `ADTC_OFF_MSTP);
  assign wr_acc = write & acc & ~(stopped & conv_reg_sel);

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic be);
    merge8 = be ? nw : old;
  endfunction : merge8

  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (address)
      `ADTC_OFF_CTRL: rd_value = {24'h00_0000, ctrl_reg};
      `ADTC_OFF_TRIG: rd_value = {24'h00_0000, trig_reg | TRIG_RSV};
      `ADTC_OFF_MSTP: rd_value = {16'h0000, mstp_reg};
      `ADTC_OFF_STAT: rd_value = {30'h0000_0000, dma_pend_reg, irq_pend_reg};
      default: rd_value = 32'h0000_0000;
    endcase
    if (stopped && conv_reg_sel)
    begin
      rd_value = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else if (req && waitrequest)
    begin
      waitrequest <= 1'b0;
      readdata <= read ? rd_value : 32'h0000_0000;
    end
    else
    begin
      waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------
  // Module stop register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      mstp_reg <= `ADTC_MSTP_RESET;
    end
    else if (wr_acc && address == `ADTC_OFF_MSTP)
    begin
      mstp_reg[7:0] <= merge8(mstp_reg[7:0], writedata[7:0], byteenable[0]);
      mstp_reg[15:8] <= merge8(mstp_reg[15:8], writedata[15:8], byteenable[1]);
    end
  end

  // ----------------------------------------
  // Trigger select register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      trig_reg <= `ADTC_TRIG_RESET;
    end
    else if (stopped || sby_sync_reg[1])
    begin
      trig_reg <= `ADTC_TRIG_RESET;
    end
    else if (wr_acc && address == `ADTC_OFF_TRIG && byteenable[0])
    begin
      trig_reg <= (writedata[7:0] & ~TRIG_RSV) | TRIG_RSV;
    end
  end

  // ----------------------------------------
  // Control register and start flag
  // ----------------------------------------
  logic trig_hit;
  adtc_trig_src_t src;

  assign src = adtc_trig_src_t'(trig_reg[`ADTC_TRIG_SEL_MSB:`ADTC_TRIG_SEL_LSB]);

  always_comb
  begin
    trig_hit = 1'b0;
    unique case (src)
      ADTC_TRG_OFF: trig_hit = 1'b0;
      ADTC_TRG_GTU: trig_hit = gtu_trigger;
      ADTC_TRG_TMR8: trig_hit = tmr8_trigger;
      ADTC_TRG_PIN: trig_hit = pin_prev_reg & ~pin_sync_reg[1];
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctrl_reg <= `ADTC_CTRL_RESET;
    end
    else
    begin
      if (wr_acc && address == `ADTC_OFF_CTRL && byteenable[0])
      begin
        ctrl_reg[`ADTC_CTRL_SCAN:0] <= writedata[`ADTC_CTRL_SCAN:0];
        ctrl_reg[`ADTC_CTRL_START] <= writedata[`ADTC_CTRL_START];
      end
      else if (conv_done)
      begin
        ctrl_reg[`ADTC_CTRL_START] <= 1'b0;
      end
      if (trig_hit && !stopped && !ctrl_reg[`ADTC_CTRL_START])
      begin
        ctrl_reg[`ADTC_CTRL_START] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= trig_hit & ~stopped & ~ctrl_reg[`ADTC_CTRL_START];
    end
  end

  // ----------------------------------------
  // Channel decode
  // ----------------------------------------
  adtc_chan_if chan ();

  assign chan.code = ctrl_reg[`ADTC_CTRL_CODE_MSB:`ADTC_CTRL_CODE_LSB];
  assign chan.scan = ctrl_reg[`ADTC_CTRL_SCAN];

  adtc_chan_decode u_decode (
    .ch(chan.dec)
  );

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      chan_sel <= 8'h01;
      adc_stopped <= 1'b1;
    end
    else
    begin
      chan_sel <= chan.mask;
      adc_stopped <= stopped;
    end
  end

  // ----------------------------------------
  // Pending requests
  // ----------------------------------------
  logic stat_clr_irq;
  logic stat_clr_dma;

  assign stat_clr_irq = wr_acc && address == `ADTC_OFF_STAT && byteenable[0] && writedata[`ADTC_STAT_IRQ];
  assign stat_clr_dma = wr_acc && address == `ADTC_OFF_STAT && byteenable[0] && writedata[`ADTC_STAT_DMA];

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      irq_pend_reg <= 1'b0;
      dma_pend_reg <= 1'b0;
    end
    else
    begin
      if (conv_done && irq_enable)
      begin
        irq_pend_reg <= 1'b1;
      end
      else if (stat_clr_irq && !stopped)
      begin
        irq_pend_reg <= 1'b0;
      end
      if (conv_done && irq_enable)
      begin
        dma_pend_reg <= 1'b1;
      end
      else if ((stat_clr_dma || dma_ack) && !stopped)
      begin
        dma_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      irq_out <= 1'b0;
      dma_req <= 1'b0;
    end
    else
    begin
      irq_out <= irq_pend_reg;
      dma_req <= dma_pend_reg;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_stop_write;
    write && !waitrequest && address == `ADTC_OFF_MSTP && byteenable[1];
  endsequence

  sequence s_conv_read;
    read && !waitrequest && address != `ADTC_OFF_MSTP;
  endsequence

  a_irq_hold_stop: assert property (stopped && irq_pend_reg ##1 stopped |-> irq_pend_reg)
    else $error("pending request cleared in module stop");
  a_chan_single: assert property (!ctrl_reg[3] |=> chan_sel == 8'(8'h01 << $past(ctrl_reg[2:0])))
    else $error("single channel mask wrong");
  a_chan_scan_all: assert property (ctrl_reg[3:0] == 4'hf |=> chan_sel == 8'hf0)
    else $error("scan group mask wrong");
  a_trig_stop_reset: assert property (stopped |=> trig_reg == 8'h3f)
    else $error("trigger register not reset in stop");
  a_trig_source: assert property (conv_start |-> $past(src) != ADTC_TRG_OFF && !$past(stopped))
    else $error("start without enabled source");
  a_resv_ones: assert property ((trig_reg & TRIG_RSV) == TRIG_RSV)
    else $error("reserved trigger bits not one");
  a_stop_after_cycle: assert property (s_stop_write ##0 writedata[9] |=> stopped ##1 adc_stopped)
    else $error("module stop not entered");
  a_stop_release: assert property (s_stop_write ##0 !writedata[9] |=> !stopped ##1 !adc_stopped)
    else $error("module stop not released");
  a_stop_read_zero: assert property (s_conv_read ##0 stopped |-> readdata == 32'h0)
    else $error("converter register read in stop");
  a_stop_no_write: assert property (stopped && write && !waitrequest && address == `ADTC_OFF_CTRL
    |=> $stable(ctrl_reg[3:0]))
    else $error("converter register written in stop");
  a_mstp_reset: assert property ($rose(rst_n_sync) |-> mstp_reg == 16'h3fff)
    else $error("module stop register reset value wrong");
  a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

endmodule : adtc_top

/* File: adtc_top_tb.sv */
// Purpose: Self-checking bench for the converter control top
// Assumes: Basic variant; testbench is the Avalon-MM master on clk
// Notes: Read data are checked against a queue of expected values
`timescale 1ns/100ps
`include "adtc_params.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module adtc_top_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic sw_standby = 1'b0;
  logic gtu_trigger = 1'b0;
  logic tmr8_trigger = 1'b0;
  logic external_trigger_pin_n = 1'b1;
  logic conv_done = 1'b0;
  logic irq_enable = 1'b0;
  logic dma_ack = 1'b0;
  logic [31:0] readdata;
  logic waitrequest;
  logic conv_start;
  logic [7:0] chan_sel;
  logic adc_stopped;
  logic irq_out;
  logic dma_req;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'hdcf1;
  logic [31:0] expq[$];
  logic [31:0] ev;
  logic [31:0] d;
  logic got;

  adtc_top #(.EXT_VARIANT(1'b0)) dut_u (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sw_standby(sw_standby), .gtu_trigger(gtu_trigger),
    .tmr8_trigger(tmr8_trigger), .external_trigger_pin_n(external_trigger_pin_n),
    .conv_done(conv_done), .irq_enable(irq_enable), .dma_ack(dma_ack), .conv_start(conv_start),
    .chan_sel(chan_sel), .adc_stopped(adc_stopped), .irq_out(irq_out), .dma_req(dma_req));

  initial forever #5 clk = ~clk;

  // ----------------------------------------
  // Closing report and hang guard
  // ----------------------------------------
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      final_report;
    end
  end

  // ----------------------------------------
  // Read data monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
    begin
      ev = (expq.size() > 0) ? expq.pop_front() : 32'hdead;
      `CHK("readdata", ev, readdata)
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dat, input logic [31:0] e);
    int n;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= dat;
    if (!w)
      expq.push_back(e);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    `CHK("bus_latency", `ADTC_BUS_WAIT_CYCLES + 1, n)
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat, 32'h0);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic pulse_ack;
    @(posedge clk) dma_ack <= 1'b1;
    @(posedge clk) dma_ack <= 1'b0;
    tick(2);
  endtask : pulse_ack

  function automatic logic [7:0] chmask(input logic [3:0] c);
    if (!c[3])
      return 8'h01 << c[2:0];
    return ((8'h02 << c[1:0]) - 8'h01) << {c[2], 2'b00};
  endfunction : chmask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    tick(4);
    resetn <= 1'b1;
    tick(3);
    `CHK("chan_sel", 8'h01, chan_sel)
    `CHK("adc_stopped", 1'b1, adc_stopped)
    rd(`ADTC_OFF_MSTP, 32'h3fff);
    wr(`ADTC_OFF_CTRL, 32'h5);
    rd(`ADTC_OFF_CTRL, 32'h0);
    wr(`ADTC_OFF_MSTP, 32'h3dff);
    tick(2);
    `CHK("adc_stopped", 1'b0, adc_stopped)
    rd(`ADTC_OFF_CTRL, 32'h0);
    rd(`ADTC_OFF_TRIG, 32'h3f);
    for (int c = 0; c < 16; c++)
    begin
      wr(`ADTC_OFF_CTRL, c);
      tick(2);
      `CHK("chan_sel", chmask(c[3:0]), chan_sel)
    end
    irq_enable <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      d = $random(seed);
      d[7:6] = s[1:0];
      d[3:2] = 2'b11;
      wr(`ADTC_OFF_TRIG, d);
      rd(`ADTC_OFF_TRIG, {24'h0, s[1:0], 6'h3f});
      @(posedge clk);
      gtu_trigger <= (s == 1);
      tmr8_trigger <= (s == 2);
      external_trigger_pin_n <= (s != 3);
      got = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
        @(posedge clk);
        gtu_trigger <= 1'b0;
        tmr8_trigger <= 1'b0;
        external_trigger_pin_n <= 1'b1;
        got = got | conv_start;
      end
      `CHK("conv_start", (s != 0), got)
      if (s != 0)
      begin
        rd(`ADTC_OFF_CTRL, 32'h1f);
        @(posedge clk) conv_done <= 1'b1;
        @(posedge clk) conv_done <= 1'b0;
      end
    end
    tick(2);
    `CHK("irq_out", 1'b1, irq_out)
    `CHK("dma_req", 1'b1, dma_req)
    irq_enable <= 1'b0;
    wr(`ADTC_OFF_MSTP, 32'h3fff);
    tick(2);
    `CHK("adc_stopped", 1'b1, adc_stopped)
    wr(`ADTC_OFF_STAT, 32'h3);
    pulse_ack;
    `CHK("irq_out", 1'b1, irq_out)
    `CHK("dma_req", 1'b1, dma_req)
    rd(`ADTC_OFF_TRIG, 32'h0);
    wr(`ADTC_OFF_MSTP, 32'h3dff);
    tick(2);
    rd(`ADTC_OFF_TRIG, 32'h3f);
    wr(`ADTC_OFF_STAT, 32'h1);
    pulse_ack;
    `CHK("irq_out", 1'b0, irq_out)
    `CHK("dma_req", 1'b0, dma_req)
    wr(`ADTC_OFF_TRIG, 32'hc0);
    rd(`ADTC_OFF_TRIG, 32'hff);
    sw_standby <= 1'b1;
    tick(4);
    rd(`ADTC_OFF_TRIG, 32'h3f);
    rd(`ADTC_OFF_MSTP, 32'h3dff);
    sw_standby <= 1'b0;
    rd(5'h10, 32'h0);
    wr(5'h14, 32'hffffffff);
    rd(`ADTC_OFF_MSTP, 32'h3dff);
    byteenable <= 4'h1;
    wr(`ADTC_OFF_MSTP, 32'h0000_ff00);
    byteenable <= 4'hf;
    rd(`ADTC_OFF_MSTP, 32'h3d00);
    tick(2);
    final_report;
  end
endmodule : adtc_top_tb
